// file: core/acr_map.svh
// register offsets, field positions and reset values of the converter control block
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH
`define ACR_OFS_CTRL      8'he1
`define ACR_OFS_RESHI     8'he2
`define ACR_OFS_RESLO     8'he3
`define ACR_OFS_PWR       8'he4
`define ACR_OFS_ISTAT     8'he5
`define ACR_OFS_IMASK     8'he6
`define ACR_CTRL_CHAN_LSB 0
`define ACR_CTRL_START    3
`define ACR_CTRL_DONE     4
`define ACR_PWR_ENN       0
`define ACR_PWR_RSV7      7
`define ACR_RST_PWR       8'h81
`define ACR_RST_CTRL      8'h00
`define ACR_RST_MASK      2'h0
`define ACR_IRQ_DONE      0
`define ACR_IRQ_LOCKED    1
`endif

// file: core/acr_pkg.sv
// types of the converter control block
package acr_pkg;
   typedef struct packed {
      logic       valid;
      logic [9:0] data;
   } acr_result_t;

   typedef struct packed {
      logic       powerOn;
      logic       start;
      logic [2:0] chan;
   } acr_conv_t;

   typedef enum logic [1:0] {
      ACR_IDLE,
      ACR_BUSY,
      ACR_DONE
   } acr_state_t;
endpackage

// file: core/acr_sync2.sv
// two-flip-flop synchroniser for a bundle of levels
`timescale 1ns/10ps
module acr_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstB,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   if (W < 1)
   begin : g_badWidth
      $error("synchroniser width must be at least 1");
   end

   always_ff @(posedge clk or negedge rstB)
   begin
      if (!rstB)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// file: core/acr_core.sv
// channel select, result and analog enable registers of the converter
`timescale 1ns/10ps
`include "acr_map.svh"
module acr_core #(
   parameter int RES_W  = 10,
   parameter int CHAN_W = 3
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic [7:0]           addr,
   input  wire logic [7:0]           wrData,
   input  wire logic                 wrStb,
   input  wire logic                 rdStb,
   output logic      [7:0]           rdData,
   output logic                      irq,
   output acr_pkg::acr_conv_t        convCtrl,
   input  wire acr_pkg::acr_result_t convResult
);
   // ==========================================
   // elaboration checks
   // the register map has room for eight inputs and a 10-bit result only
   if (CHAN_W != 3 || CHAN_W != $bits(acr_pkg::acr_conv_t) - 2)
   begin : g_chanWidth
      $error("channel select width must be 3 bits");
   end
   if (RES_W != 10 || RES_W != $bits(acr_pkg::acr_result_t) - 1)
   begin : g_resWidth
      $error("result width must be 10 bits");
   end

   // ==========================================
   // reset release and result capture
   logic rstMeta;
   logic rstB;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta <= 1'b0;
         rstB    <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstB    <= rstMeta;
      end
   end

   // converter core runs on its own timing, so resync its result
   acr_pkg::acr_result_t resSync;

   acr_sync2 #(
      .W ($bits(acr_pkg::acr_result_t))
   ) uResSync (
      .clk  (clk),
      .rstB (rstB),
      .d    (convResult),
      .q    (resSync)
   );

   // ==========================================
   // state
   typedef struct packed {
      acr_pkg::acr_state_t st;
      logic [2:0]          chan;
      logic                start;
      logic                done;
      logic [7:0]          resHi;
      logic [1:0]          resLo;
      logic [7:0]          pwr;
      logic [1:0]          istat;
      logic [1:0]          imask;
      logic                validPrev;
      logic                validOld;
      logic [7:0]          rdData;
      logic                irq;
      acr_pkg::acr_conv_t  conv;
   } acr_core_state_t;

   acr_core_state_t s_r;
   acr_core_state_t s_nxt;

   // a running conversion is dropped on reset; start falls at once
   localparam acr_core_state_t RST_STATE = '{
      st:        acr_pkg::ACR_IDLE,
      chan:      3'h0,
      start:     1'h0,
      done:      1'h0,
      resHi:     8'h00,
      resLo:     2'h0,
      pwr:       `ACR_RST_PWR,
      istat:     2'h0,
      imask:     `ACR_RST_MASK,
      validPrev: 1'h0,
      validOld:  1'h0,
      rdData:    8'h00,
      irq:       1'h0,
      conv:      '0
   };

   // ==========================================
   // next state
   always_comb
   begin
      logic finish;
      logic ctrlWr;
      logic [1:0] evt;
      finish = 1'b0;
      ctrlWr = 1'b0;
      evt    = 2'h0;
      s_nxt  = s_r;
      // take the word one cycle after valid rose, so every data bit has settled
      finish = resSync.valid & s_r.validPrev & ~s_r.validOld & (s_r.st == acr_pkg::ACR_BUSY);
      ctrlWr = wrStb && (addr == `ACR_OFS_CTRL);
      s_nxt.validPrev = resSync.valid;
      s_nxt.validOld  = s_r.validPrev;

      case (s_r.st)
         acr_pkg::ACR_IDLE:
         begin
            if (s_r.start && !s_r.done)
               s_nxt.st = acr_pkg::ACR_BUSY;
         end
         acr_pkg::ACR_BUSY:
         begin
            if (finish)
            begin
               // high and low parts land together, never a torn pair
               s_nxt.resHi = resSync.data[RES_W-1:2];
               s_nxt.resLo = resSync.data[1:0];
               s_nxt.done  = 1'b1;
               s_nxt.start = 1'b0;
               s_nxt.st    = acr_pkg::ACR_DONE;
               evt[`ACR_IRQ_DONE] = 1'b1;
            end
         end
         acr_pkg::ACR_DONE:
         begin
            if (!s_r.done)
               s_nxt.st = acr_pkg::ACR_IDLE;
         end
         default:
         begin
            s_nxt.st = acr_pkg::ACR_IDLE;
         end
      endcase

      if (ctrlWr)
      begin
         // locked while a conversion runs or its flag is pending
         if (!s_r.start && !s_r.done)
            s_nxt.chan = wrData[`ACR_CTRL_CHAN_LSB +: CHAN_W];
         else if (wrData[`ACR_CTRL_CHAN_LSB +: CHAN_W] != s_r.chan)
            evt[`ACR_IRQ_LOCKED] = 1'b1;
         // done may only be cleared by software; setting it is ignored
         if (!wrData[`ACR_CTRL_DONE] && !finish)
            s_nxt.done = 1'b0;
         if (wrData[`ACR_CTRL_START])
            s_nxt.start = 1'b1;
      end
      else if (wrStb && addr == `ACR_OFS_PWR)
         s_nxt.pwr[`ACR_PWR_ENN] = wrData[`ACR_PWR_ENN];
      else if (wrStb && addr == `ACR_OFS_IMASK)
         s_nxt.imask = wrData[1:0];

      // set wins over write-one-to-clear
      if (wrStb && addr == `ACR_OFS_ISTAT)
         s_nxt.istat = (s_r.istat & ~wrData[1:0]) | evt;
      else
         s_nxt.istat = s_r.istat | evt;

      // zero outside the read slot, so stale data never lingers on the bus
      s_nxt.rdData = 8'h00;
      if (rdStb)
      begin
         if (addr == `ACR_OFS_CTRL)
            s_nxt.rdData = {3'h0, s_r.done, s_r.start, s_r.chan};
         else if (addr == `ACR_OFS_RESHI)
            s_nxt.rdData = s_r.resHi;
         else if (addr == `ACR_OFS_RESLO)
            s_nxt.rdData = {6'h00, s_r.resLo};
         else if (addr == `ACR_OFS_PWR)
            s_nxt.rdData = s_r.pwr;
         else if (addr == `ACR_OFS_ISTAT)
            s_nxt.rdData = {6'h00, s_r.istat};
         else if (addr == `ACR_OFS_IMASK)
            s_nxt.rdData = {6'h00, s_r.imask};
         else
            s_nxt.rdData = 8'h00;
      end

      s_nxt.irq          = |(s_nxt.istat & s_nxt.imask);
      s_nxt.conv.chan    = s_nxt.chan;
      s_nxt.conv.powerOn = ~s_nxt.pwr[`ACR_PWR_ENN];
      s_nxt.conv.start   = s_nxt.start & ~s_nxt.done & ~s_nxt.pwr[`ACR_PWR_ENN];
   end

   // ==========================================
   // registers
   always_ff @(posedge clk or negedge rstB)
   begin
      if (!rstB)
      begin
         s_r <= RST_STATE;
      end
      else
         s_r <= s_nxt;
   end

   assign rdData   = s_r.rdData;
   assign irq      = s_r.irq;
   assign convCtrl = s_r.conv;
endmodule

// file: verif/acr_core_properties.sv
// port checker of the converter control block
`timescale 1ns/10ps
module acr_core_check (
   input wire logic                 clk,
   input wire logic                 rst_b,
   input wire logic [7:0]           addr,
   input wire logic [7:0]           wrData,
   input wire logic                 wrStb,
   input wire logic                 rdStb,
   input wire logic [7:0]           rdData,
   input wire logic                 irq,
   input wire acr_pkg::acr_conv_t   convCtrl,
   input wire acr_pkg::acr_result_t convResult
);
   // ====
   // steps
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence ctrlWrite;
      wrStb && addr == 8'he1;
   endsequence
   sequence finish;
      $rose(convResult.valid) && convCtrl.start;
   endsequence
   // ====
   // properties
   a_chan_locked: assert property (ctrlWrite ##0 convCtrl.start |=> $stable(convCtrl.chan))
      else $error("channel moved while busy");
   a_power_on: assert property (wrStb && addr == 8'he4 && !wrData[0] |=> convCtrl.powerOn)
      else $error("converter not powered");
   a_power_off: assert property (wrStb && addr == 8'he4 && wrData[0] |=> !convCtrl.powerOn)
      else $error("converter still powered");
   a_start_powered: assert property (convCtrl.start |-> convCtrl.powerOn)
      else $error("start while unpowered");
   a_reset_off: assert property ($rose(rst_b) |-> !convCtrl.powerOn [*2])
      else $error("powered after reset");
   a_done_stop: assert property (finish |-> ##[1:5] !convCtrl.start)
      else $error("start kept after finish");
   a_read_idle: assert property (!$past(rdStb) |-> rdData == 8'h00)
      else $error("read data outside slot");
endmodule
bind acr_core acr_core_check i_chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
   .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq), .convCtrl(convCtrl),
   .convResult(convResult));

// file: verif/acr_conv_model.sv
// behavioural analog conversion core
`timescale 1ns/10ps
module acr_conv_model #(
   parameter int DLY = 5
) (
   input  wire logic                 clk,
   input  wire acr_pkg::acr_conv_t   conv,
   output acr_pkg::acr_result_t      res = '0
);
   int n = 0;
   // ====
   // conversion
   always @(posedge clk)
   begin
      n <= (conv.start && conv.powerOn) ? n + 1 : 0;
      res.valid <= n >= DLY;
      // idle data toggles so stale values never look valid
      res.data <= (n >= DLY) ? {conv.chan, 7'h5a} : ~res.data;
   end
endmodule

// file: verif/adc_channel_result_regs_bench.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module adc_channel_result_regs_bench;
   logic                 clk = 0;
   logic                 rst_b = 0;
   logic                 wrStb = 0;
   logic                 rdStb = 0;
   logic [7:0]           addr = 0;
   logic [7:0]           wrData = 0;
   logic [7:0]           rdData;
   logic                 irq;
   logic [9:0]           e;
   acr_pkg::acr_conv_t   cc;
   acr_pkg::acr_result_t cr;
   int                   fail_count = 0;
   int                   checked = 0;
   int                   k;
   acr_core i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrStb(wrStb),
      .rdStb(rdStb), .rdData(rdData), .irq(irq), .convCtrl(cc), .convResult(cr));
   acr_conv_model i_conv (.clk(clk), .conv(cc), .res(cr));
   initial forever #10 clk = ~clk;
   task summarize;
      $display("checked %0d bad %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wrStb <= 1;
      addr <= a;
      wrData <= d;
      @(posedge clk);
      wrStb <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      rdStb <= 1;
      addr <= a;
      @(posedge clk);
      rdStb <= 0;
      #1 `CHK(rdData, x)
   endtask
   // ====
   // sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      rd(8'he4, 8'h81);
      `CHK(cc.powerOn, 1'b0)
      rd(8'h10, 8'h00);
      wr(8'he6, 8'h01);
      for (int c = 0; c < 8; c++)
      begin
         e = {c[2:0], 7'h5a};
         wr(8'he4, 8'h00);
         wr(8'he1, {5'h01, c[2:0]});
         #1 `CHK(cc.powerOn, 1'b1)
         // a channel write while converting must leave the channel alone
         wr(8'he1, {5'h01, ~c[2:0]});
         #1 `CHK(cc.start, 1'b1)
         for (k = 0; k < 60 && irq !== 1'b1; k++) #20;
         if (irq !== 1'b1)
         begin
            fail_count++;
            $display("BAD %0t no done interrupt", $time);
            summarize;
         end
         // bit4 set so the refused write cannot clear done
         wr(8'he1, {5'h02, ~c[2:0]});
         #1 `CHK(cc.chan, c[2:0])
         rd(8'he1, {5'h02, c[2:0]});
         rd(8'he2, e[9:2]);
         rd(8'he3, {6'h00, e[1:0]});
         rd(8'he5, 8'h03);
         wr(8'he1, {5'h00, c[2:0]});
         wr(8'he5, 8'h03);
         @(posedge clk);
         #1 `CHK(irq, 1'b0)
         $display("test channel %0d over", c);
      end
      wr(8'he4, 8'h01);
      #1 `CHK(cc.powerOn, 1'b0)
      // unpowered start: start stays low, channel locked, locked event raises irq
      wr(8'he6, 8'h02);
      wr(8'he1, 8'h0a);
      #1 `CHK(cc.chan, 3'h2)
      `CHK(cc.start, 1'b0)
      wr(8'he1, 8'h0d);
      #1 `CHK(irq, 1'b1)
      `CHK(cc.chan, 3'h2)
      $display("test locked write over");
      @(posedge clk);
      rst_b <= 0;
      repeat (2) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      rd(8'he4, 8'h81);
      rd(8'he1, 8'h00);
      `CHK(cc.powerOn, 1'b0)
      $display("test second reset over");
      summarize;
   end
endmodule
